// ===== hw/nsr_host.sv
// nsr_host.sv: apb-controlled host that reads status, unique id and parameter page of a nand flash
// assumes: one 200 MHz clock; flash pins wired straight to pins_o / dq_i / ready_busy_line_i
//
// How it works
// - status mode lasts until next command; 00h resumes data output
// - 78h is followed by three row address cycles of the executed operation
// - after enhanced status, 00h then optional 06h-E0h before data output
// - 78h is refused while one-time-programmable mode is active
// - copy accepted only if id xor complement is all ones, else next copy
// - programming pages must go in ascending page order within a block
// - at most four partial programs per page before erase
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "nsr_map.svh"
module nsr_host
(
  // clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // apb slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output logic [31:0]             prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  // flash pins
  input  wire logic [7:0]         dq_i,
  input  wire logic               ready_busy_line_i,
  output nsr_pkg::nsr_pins_t      pins_o
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000, ST_CMD = 3'b001, ST_ADDR = 3'b010, ST_WAIT = 3'b011,
    ST_READ = 3'b100, ST_CMD2 = 3'b101, ST_DONE = 3'b110
  } nsr_st_t;

  // ----------------------------------------------------------------------------
  // synchronisers for pins
  // ----------------------------------------------------------------------------
  logic [7:0] dq_s1, dq_s2, dq_s3;
  logic       rb_s1, rb_s2, rb_s3, rb_ok;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {dq_s1, dq_s2, dq_s3} <= 24'h000000;
      {rb_s1, rb_s2, rb_s3} <= 3'h0;
      rb_ok                 <= 1'b0;
    end
    else
    begin
      dq_s1 <= dq_i;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      rb_s1 <= ready_busy_line_i;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (rb_s2 == rb_s3)
        rb_ok <= rb_s3; // ready line counted once two stages agree
    end
  end
  logic [7:0] dq_ok;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      dq_ok <= 8'h00;
    else
      for (int i = 0; i < 8; i++)
        if (dq_s2[i] == dq_s3[i])
          dq_ok[i] <= dq_s3[i];
  end

  // ----------------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------------
  logic [2:0]   op;
  logic         otp_mode, x16_mode, busy, err_refused, uid_ok, uid_fail, order_err, partial_err;
  logic [23:0]  row_addr;
  logic [7:0]   status_byte;
  logic [127:0] uid;
  logic [31:0]  geom, times;
  logic [17:0]  last_page;
  logic [2:0]   partial_cnt;
  logic         wr_go, apb_wr, apb_rd;
  assign apb_wr   = psel_i && penable_i && pwrite_i;
  assign apb_rd   = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign wr_go    = apb_wr && paddr_i == `NSR_OFF_CTRL && pwdata_i[`NSR_CTRL_GO] && !busy;

  // ctrl and address registers
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      op       <= `NSR_OP_STATUS;
      otp_mode <= 1'b0;
      x16_mode <= 1'b0;
      row_addr <= 24'h000000;
    end
    else if (apb_wr && paddr_i == `NSR_OFF_CTRL && !busy)
    begin
      op       <= pwdata_i[`NSR_CTRL_OP_HI:`NSR_CTRL_OP_LO];
      otp_mode <= pwdata_i[`NSR_CTRL_OTP];
      x16_mode <= pwdata_i[`NSR_CTRL_X16];
    end
    else if (apb_wr && paddr_i == `NSR_OFF_ADDR)
      row_addr <= pwdata_i[23:0];
  end

  // order / partial program checker, software reports each program
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      last_page   <= 18'h00000;
      partial_cnt <= 3'h0;
      order_err   <= 1'b0;
      partial_err <= 1'b0;
    end
    else if (wr_go && pwdata_i[`NSR_CTRL_OP_HI:`NSR_CTRL_OP_LO] == `NSR_OP_PROGCHK)
    begin
      if (row_addr[17:6] != last_page[17:6] || row_addr[5:0] > last_page[5:0])
        partial_cnt <= 3'h1;
      else if (row_addr[5:0] == last_page[5:0])
      begin
        partial_cnt <= partial_cnt + 3'h1;
        if (partial_cnt >= `NSR_MAX_PARTIAL)
          partial_err <= 1'b1;
      end
      else
        order_err <= 1'b1;
      last_page <= row_addr[17:0];
    end
  end

  // ----------------------------------------------------------------------------
  // sequence engine
  // ----------------------------------------------------------------------------
  nsr_st_t           state;
  nsr_pkg::nsr_cyc_t cyc;
  logic              cyc_req, cyc_done, hold_rel;
  logic [7:0]        cyc_data;
  logic [1:0]        addr_n;
  logic [9:0]        idx;
  logic [9:0]        wait_cnt;
  logic [127:0]      cmp;

  function automatic logic [7:0] cmd_of(input logic [2:0] o);
    unique case (o)
      `NSR_OP_ENH:    cmd_of = `NSR_CMD_ENH;
      `NSR_OP_UID:    cmd_of = `NSR_CMD_UID;
      `NSR_OP_PARAM:  cmd_of = `NSR_CMD_PARAM;
      `NSR_OP_NORMAL: cmd_of = `NSR_CMD_READ;
      default:        cmd_of = `NSR_CMD_STATUS;
    endcase
  endfunction

  // read byte index within the current copy
  function automatic logic [8:0] pp_off(input logic [9:0] i);
    pp_off = i[8:0] & (`NSR_PP_COPY_LEN - 9'h001);
  endfunction

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state       <= ST_IDLE;
      busy        <= 1'b0;
      err_refused <= 1'b0;
      addr_n      <= 2'h0;
      idx         <= 10'h000;
      wait_cnt    <= 10'h000;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (wr_go)
          begin
            if (pwdata_i[`NSR_CTRL_OP_HI:`NSR_CTRL_OP_LO] == `NSR_OP_PROGCHK)
              state <= ST_IDLE;
            else if (pwdata_i[`NSR_CTRL_OP_HI:`NSR_CTRL_OP_LO] == `NSR_OP_ENH && pwdata_i[`NSR_CTRL_OTP])
              err_refused <= 1'b1;
            else
            begin
              busy        <= 1'b1;
              err_refused <= 1'b0;
              state       <= ST_CMD; // no wait for ready before 78h
            end
          end
        end
        ST_CMD:
        begin
          if (cyc_done)
          begin
            addr_n   <= 2'h0;
            idx      <= 10'h000;
            wait_cnt <= 10'(`NSR_WHR_CYC); // turnaround before the first read
            if (op == `NSR_OP_ENH)
              state <= ST_ADDR;
            else if (op == `NSR_OP_UID || op == `NSR_OP_PARAM)
              state <= ST_ADDR;
            else
              state <= ST_WAIT;
          end
        end
        ST_ADDR:
        begin
          if (cyc_done)
          begin
            addr_n <= addr_n + 2'h1;
            if (op != `NSR_OP_ENH || addr_n == `NSR_ROW_CYCLES - 2'h1)
            begin
              wait_cnt <= 10'(`NSR_WHR_CYC);
              state    <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          if (wait_cnt != 10'h000)
            wait_cnt <= wait_cnt - 10'h001;
          else if ((op == `NSR_OP_UID || op == `NSR_OP_PARAM) && !rb_ok)
            state <= ST_WAIT;
          else if (op == `NSR_OP_NORMAL)
            state <= ST_DONE;
          else
            state <= ST_READ;
        end
        ST_READ:
        begin
          if (cyc_done)
          begin
            idx <= idx + 10'h001;
            if (op == `NSR_OP_STATUS || op == `NSR_OP_ENH)
              state <= ST_DONE;
            else if (op == `NSR_OP_UID && (uid_ok || idx[8:0] == 9'h1FF))
              state <= ST_DONE;
            else if (op == `NSR_OP_PARAM && pp_off(idx) == `NSR_PP_TIME_LAST)
              state <= ST_DONE;
          end
        end
        ST_CMD2:
          state <= ST_DONE;
        ST_DONE:
        begin
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // status byte captured live while the strobe is held low
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      status_byte <= 8'h00;
    else if (state == ST_READ && !pins_o.read_strobe_low && (op == `NSR_OP_STATUS || op == `NSR_OP_ENH))
      status_byte <= dq_ok;
  end

  // unique id capture and complement check
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      uid      <= '0;
      cmp      <= '0;
      uid_ok   <= 1'b0;
      uid_fail <= 1'b0;
    end
    else if (wr_go)
    begin
      uid_ok   <= 1'b0;
      uid_fail <= 1'b0;
    end
    else if (state == ST_READ && op == `NSR_OP_UID && cyc_done && !uid_ok)
    begin
      if (idx[4] == 1'b0)
        uid <= {cyc_data, uid[127:8]};
      else
        cmp <= {cyc_data, cmp[127:8]};
      if (idx[4:0] == 5'h1F)
      begin
        if ((uid ^ {cyc_data, cmp[127:8]}) == {128{1'b1}})
          uid_ok <= 1'b1;
        else if (idx[8:5] == 4'(`NSR_UID_COPIES - 5'h01))
          uid_fail <= 1'b1;
      end
    end
  end

  // parameter page fields, little-endian bytes
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      geom  <= 32'h00000000;
      times <= 32'h00000000;
    end
    else if (state == ST_READ && op == `NSR_OP_PARAM && cyc_done)
    begin
      unique case (pp_off(idx))
        9'h05C: geom[7:0]    <= cyc_data;
        9'h061: geom[15:8]   <= cyc_data;
        9'h064: geom[19:16]  <= cyc_data[3:0];
        9'h065: geom[27:20]  <= cyc_data;
        9'h06E: geom[31:28]  <= cyc_data[3:0];
        9'h085: times[7:0]   <= cyc_data;
        9'h086: times[15:8]  <= cyc_data;
        9'h087: times[23:16] <= cyc_data;
        9'h088: times[31:24] <= cyc_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // pin cycle requests
  // ----------------------------------------------------------------------------
  always_comb
  begin
    cyc     = '0;
    cyc_req = 1'b0;
    unique case (state)
      ST_CMD:  begin cyc_req = 1'b1; cyc.is_cmd = 1'b1; cyc.data = cmd_of(op); end
      ST_ADDR: begin cyc_req = 1'b1; cyc.is_addr = 1'b1;
                 cyc.data = (op == `NSR_OP_ENH) ? row_addr[8*addr_n +: 8] : 8'h00; end
      ST_READ: begin cyc_req = 1'b1; cyc.is_read = 1'b1;
                 cyc.hold_low = (op == `NSR_OP_STATUS || op == `NSR_OP_ENH); end
      default: ;
    endcase
  end
  assign hold_rel = (state == ST_READ) && (dq_ok[`NSR_SR_RDY6] || op == `NSR_OP_ENH);

  nsr_pin_cycle u_cycle
  (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .req_i     (cyc_req && !cyc_done),
    .cyc_i     (cyc),
    .release_i (hold_rel),
    .done_o    (cyc_done),
    .rdata_o   (cyc_data),
    .dq_i      (x16_mode ? dq_ok : dq_ok), // only low lane wired
    .pins_o    (pins_o)
  );

  // ----------------------------------------------------------------------------
  // apb read mux
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else if (psel_i && !penable_i)
    begin
      pslverr_o <= 1'b0;
      unique case (paddr_i)
        `NSR_OFF_CTRL:    prdata_o <= {26'h0, x16_mode, otp_mode, op, busy};
        `NSR_OFF_ADDR:    prdata_o <= {8'h00, row_addr};
        `NSR_OFF_STAT:    prdata_o <= {26'h0, partial_err, order_err, uid_fail, uid_ok, err_refused, busy};
        `NSR_OFF_DEVSTAT: prdata_o <= {23'h0, rb_ok, status_byte & ~`NSR_SR_ZERO_MASK};
        `NSR_OFF_UID0:    prdata_o <= uid[31:0];
        `NSR_OFF_UID1:    prdata_o <= uid[63:32];
        `NSR_OFF_UID2:    prdata_o <= uid[95:64];
        `NSR_OFF_UID3:    prdata_o <= uid[127:96];
        `NSR_OFF_GEOM:    prdata_o <= geom;
        `NSR_OFF_TIMES:   prdata_o <= times;
        `NSR_OFF_PROGCHK: prdata_o <= {11'h0, partial_cnt, last_page};
        default:
        begin
          prdata_o  <= 32'h00000000;
          pslverr_o <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ===== hw/nsr_map.svh
// nsr_map.svh: offsets, fields, commands and timing counts of the status/id host
// assumes: included by bare name from the host design files
`ifndef NSR_MAP_SVH
`define NSR_MAP_SVH

// ----------------------------------------------------------------------------
// apb register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define NSR_OFF_CTRL      12'h000
`define NSR_OFF_ADDR      12'h004
`define NSR_OFF_STAT      12'h008
`define NSR_OFF_DEVSTAT   12'h00C
`define NSR_OFF_UID0      12'h010
`define NSR_OFF_UID1      12'h014
`define NSR_OFF_UID2      12'h018
`define NSR_OFF_UID3      12'h01C
`define NSR_OFF_GEOM      12'h020
`define NSR_OFF_TIMES     12'h024
`define NSR_OFF_PROGCHK   12'h028

// ----------------------------------------------------------------------------
// ctrl fields and operation codes
// ----------------------------------------------------------------------------
`define NSR_CTRL_GO       0
`define NSR_CTRL_OP_LO    1
`define NSR_CTRL_OP_HI    3
`define NSR_CTRL_OTP      4
`define NSR_CTRL_X16      5
`define NSR_OP_STATUS     3'h0
`define NSR_OP_ENH        3'h1
`define NSR_OP_UID        3'h2
`define NSR_OP_PARAM      3'h3
`define NSR_OP_NORMAL     3'h4
`define NSR_OP_PROGCHK    3'h5

// ----------------------------------------------------------------------------
// device commands
// ----------------------------------------------------------------------------
`define NSR_CMD_STATUS    8'h70
`define NSR_CMD_ENH       8'h78
`define NSR_CMD_READ      8'h00
`define NSR_CMD_UID       8'hED
`define NSR_CMD_PARAM     8'hEC
`define NSR_CMD_COLSEL    8'h06
`define NSR_CMD_CONFIRM   8'hE0

// ----------------------------------------------------------------------------
// status bits, page layouts
// ----------------------------------------------------------------------------
`define NSR_SR_FAIL       0
`define NSR_SR_PERR       1
`define NSR_SR_RDY5       5
`define NSR_SR_RDY6       6
`define NSR_SR_WP         7
`define NSR_SR_ZERO_MASK  8'h1C
`define NSR_UID_LEN       6'h10
`define NSR_UID_COPIES    5'h10
`define NSR_ROW_CYCLES    2'h3
`define NSR_PP_GEOM_FIRST 9'h05C
`define NSR_PP_GEOM_LAST  9'h06E
`define NSR_PP_TIME_FIRST 9'h085
`define NSR_PP_TIME_LAST  9'h08A
`define NSR_PP_COPY_LEN   9'h100
`define NSR_MAX_PARTIAL   3'h4

// ----------------------------------------------------------------------------
// pin timing at 200 MHz (5 ns)
// ----------------------------------------------------------------------------
`define NSR_CLK_NS        5
`define NSR_T_PULSE_NS    25
`define NSR_PULSE_CYC     ((`NSR_T_PULSE_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_T_WHR_NS      80
`define NSR_WHR_CYC       ((`NSR_T_WHR_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`endif

// ===== hw/nsr_pin_cycle.sv
// nsr_pin_cycle.sv: one bus cycle (command, address, read) on the flash pins
// assumes: flash data inputs already synchronised by the caller
`timescale 1ns/1ps
`include "nsr_map.svh"
module nsr_pin_cycle
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // request
  input  wire logic              req_i,
  input  wire nsr_pkg::nsr_cyc_t cyc_i,
  input  wire logic              release_i,
  output logic                   done_o,
  output logic [7:0]             rdata_o,
  // pins
  input  wire logic [7:0]        dq_i,
  output nsr_pkg::nsr_pins_t     pins_o
);
  typedef enum logic [1:0] {PC_IDLE = 2'b00, PC_LOW = 2'b01, PC_HIGH = 2'b10, PC_HOLD = 2'b11} nsr_pc_t;
  nsr_pc_t           state;
  logic [3:0]        cnt;
  nsr_pkg::nsr_cyc_t cur;

  // ----------------------------------------------------------------------------
  // strobe sequencing
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= PC_IDLE;
      cnt   <= 4'h0;
      cur   <= '0;
    end
    else
    begin
      unique case (state)
        PC_IDLE:
        begin
          if (req_i)
          begin
            cur   <= cyc_i;
            cnt   <= 4'(`NSR_PULSE_CYC);
            state <= PC_LOW;
          end
        end
        PC_LOW:
        begin
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else if (cur.hold_low)
            state <= PC_HOLD; // strobe held low, byte refreshes live
          else
          begin
            cnt   <= 4'(`NSR_PULSE_CYC);
            state <= PC_HIGH;
          end
        end
        PC_HIGH:
        begin
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
            state <= PC_IDLE;
        end
        PC_HOLD:
        begin
          if (release_i)
          begin
            cnt   <= 4'(`NSR_PULSE_CYC);
            state <= PC_HIGH;
          end
        end
      endcase
    end
  end

  // read data sampled at end of low phase and live while holding
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (cur.is_read && ((state == PC_LOW && cnt == 4'h0) || state == PC_HOLD))
      rdata_o <= dq_i;
  end

  // pin drive
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pins_o <= '{chip_sel_n: 1'b1, cmd_latch: 1'b0, addr_latch: 1'b0, write_strobe_n: 1'b1,
                  read_strobe_low: 1'b1, dq_out: 8'h00, dq_oe_n: 1'b1};
    end
    else
    begin
      pins_o.chip_sel_n      <= 1'b0;
      pins_o.cmd_latch       <= (state == PC_IDLE) ? (req_i && cyc_i.is_cmd) : cur.is_cmd;
      pins_o.addr_latch      <= (state == PC_IDLE) ? (req_i && cyc_i.is_addr) : cur.is_addr;
      pins_o.write_strobe_n  <= !((state == PC_IDLE && req_i && !cyc_i.is_read) || (state == PC_LOW && !cur.is_read));
      pins_o.read_strobe_low <= !((state == PC_IDLE && req_i && cyc_i.is_read) ||
                                  ((state == PC_LOW || (state == PC_HOLD && !release_i)) && cur.is_read));
      pins_o.dq_out          <= (state == PC_IDLE && req_i) ? cyc_i.data : cur.data;
      pins_o.dq_oe_n         <= (state == PC_IDLE && req_i) ? cyc_i.is_read : (state == PC_IDLE ? 1'b1 : cur.is_read);
    end
  end

  assign done_o = (state == PC_HIGH && cnt == 4'h0);
endmodule

// ===== hw/nsr_pkg.sv
// nsr_pkg.sv: types shared by the status/id host files
// assumes: nothing beyond the map header
package nsr_pkg;
  // pin outputs toward the flash
  typedef struct packed {
    logic       chip_sel_n;
    logic       cmd_latch;
    logic       addr_latch;
    logic       write_strobe_n;
    logic       read_strobe_low;
    logic [7:0] dq_out;
    logic       dq_oe_n;
  } nsr_pins_t;

  // pin-cycle request to the strobe engine
  typedef struct packed {
    logic       is_cmd;
    logic       is_addr;
    logic       is_read;
    logic       hold_low;
    logic [7:0] data;
  } nsr_cyc_t;
endpackage

// ===== testbench/nsr_flash_model.sv
// nsr_flash_model.sv: behavioural flash for status, id and parameter reads
// assumes: pins from nsr_host; busy and faults set by the bench
`timescale 1ns/1ps
module nsr_flash_model
(
  // host pins
  input  wire nsr_pkg::nsr_pins_t pins_i,
  // bench knobs
  input  wire logic               busy_i,
  input  wire logic               fail_i,
  input  wire logic               bad_uid_i,
  // flash outputs
  output logic [7:0]              dq_o,
  output logic                    ready_busy_line_o
);
  logic [7:0] cmd = 8'hFF;
  logic [7:0] row = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] cur;
  logic [9:0] idx = 10'h000;
  logic [1:0] na = 2'h0;
  logic [7:0] pg [256];
  logic       pf;
  // parameter page content, little-endian fields
  initial
  begin
    pg = '{default: 8'h00};
    pg[92] = 8'h40;
    pg[97] = 8'h10;
    pg[100] = 8'h01;
    pg[101] = 8'h23;
    pg[110] = 8'h04;
    pg[133] = 8'hBC;
    pg[134] = 8'h02;
    pg[135] = 8'h10;
    pg[136] = 8'h27;
    pg[137] = 8'h19;
  end
  // command and first row byte taken at strobe release
  always @(posedge pins_i.write_strobe_n)
  begin
    if (!pins_i.chip_sel_n && pins_i.cmd_latch)
    begin
      cmd <= pins_i.dq_out;
      idx <= 10'h000;
      na <= 2'h0;
    end
    else if (!pins_i.chip_sel_n && pins_i.addr_latch)
    begin
      na <= na + 2'h1;
      row <= (na == 2'h0) ? pins_i.dq_out : row;
    end
  end
  // next byte after each read cycle
  always @(posedge pins_i.read_strobe_low)
  begin
    last <= cur;
    idx <= idx + 10'h001;
  end
  // byte presented in the current mode, live while strobe held
  always_comb
  begin
    pf = fail_i && (cmd != 8'h78 || row[6]);
    case (cmd)
      8'h70, 8'h78: cur = {1'b1, !busy_i, !busy_i, 3'b000, pf, pf};
      8'hED: cur = (idx[4] && !(bad_uid_i && idx[9:5] == 5'h00)) ? ~{4'hC, idx[3:0]} : {4'hC, idx[3:0]};
      8'hEC: cur = pg[idx[7:0]];
      default: cur = idx[7:0] ^ 8'h5A;
    endcase
  end
  // drive only while selected and read strobe low, else inverted last
  assign dq_o = (!pins_i.chip_sel_n && !pins_i.read_strobe_low) ? cur : ~last;
  assign ready_busy_line_o = !busy_i;
endmodule

// ===== testbench/nsr_host_sva.sv
// nsr_host_sva.sv: pin and bus properties of the status/id host
// assumes: bound to nsr_host; one clock domain
`timescale 1ns/1ps
module nsr_host_sva
(
  // clock, reset, apb
  input wire logic               clock_i,
  input wire logic               rst_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pready_o,
  // flash pins
  input wire nsr_pkg::nsr_pins_t pins_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // -----------------------------
  // command cycle ending with strobe release
  // -----------------------------
  sequence cmd_done(logic [7:0] c);
    (!pins_o.write_strobe_n && pins_o.cmd_latch && pins_o.dq_out == c) ##1 pins_o.write_strobe_n;
  endsequence

  a_cmd_under_cs: assert property (pins_o.cmd_latch |-> !pins_o.chip_sel_n)
    else $error("command latched without chip select");
  a_host_drives_bus: assert property (!pins_o.write_strobe_n |-> !pins_o.dq_oe_n)
    else $error("write strobe with data lines floating");
  a_read_floats_dq: assert property (!pins_o.read_strobe_low |-> pins_o.dq_oe_n)
    else $error("host drives data during a read");
  a_strobes_apart: assert property (pins_o.write_strobe_n || pins_o.read_strobe_low)
    else $error("both strobes low");
  a_latch_apart: assert property (!(pins_o.cmd_latch && pins_o.addr_latch))
    else $error("command and address latch together");
  a_status_read_next: assert property (cmd_done(8'h70) |-> ##[1:200] !pins_o.read_strobe_low)
    else $error("no status read after status command");
  a_status_no_addr: assert property (cmd_done(8'h70) |=> !pins_o.addr_latch [*8])
    else $error("address cycle after status command");
  a_enh_row_next: assert property (cmd_done(8'h78) |-> ##[1:40] pins_o.addr_latch)
    else $error("no row address after enhanced status");
  a_wide_pulse: assert property ($fell(pins_o.write_strobe_n) |=> !pins_o.write_strobe_n [*3])
    else $error("write strobe pulse too short");
  a_zero_wait: assert property (psel_i && penable_i |-> pready_o)
    else $error("apb access without ready");
endmodule

bind nsr_host nsr_host_sva nsr_host_sva_i
(
  .clock_i   (clock_i),
  .rst_i     (rst_i),
  .psel_i    (psel_i),
  .penable_i (penable_i),
  .pready_o  (pready_o),
  .pins_o    (pins_o)
);

// ===== testbench/test_nsr_host.sv
// test_nsr_host.sv: apb-driven scenarios for the status/id host
// assumes: nsr_pkg compiled; checker bound from its own file
`timescale 1ns/1ps
`include "nsr_map.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %h seen %h", n, e, a); end end
module test_nsr_host;
  logic               clock_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               psel_i = 1'b0;
  logic               penable_i = 1'b0;
  logic               pwrite_i = 1'b0;
  logic [11:0]        paddr_i = 12'h000;
  logic [31:0]        pwdata_i = 32'h0;
  logic [31:0]        prdata_o;
  logic               pready_o;
  logic               pslverr_o;
  logic [7:0]         flash_dq;
  logic [7:0]         dq_i;
  logic               ready_busy_line_i;
  logic               busy = 1'b0;
  logic               fail = 1'b0;
  logic               bad_uid = 1'b0;
  logic [31:0]        rd;
  logic               err;
  int                 n_fail = 0;
  int                 checked = 0;
  nsr_pkg::nsr_pins_t pins_o;

  always #2.5 clock_i = ~clock_i;
  // data wire: host when it drives, else the flash
  assign dq_i = pins_o.dq_oe_n ? flash_dq : pins_o.dq_out;

  nsr_host nsr_host_i (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .dq_i(dq_i), .ready_busy_line_i(ready_busy_line_i), .pins_o(pins_o));
  nsr_flash_model nsr_flash_model_i (.pins_i(pins_o), .busy_i(busy), .fail_i(fail), .bad_uid_i(bad_uid),
    .dq_o(flash_dq), .ready_busy_line_o(ready_busy_line_i));

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do
      @(posedge clock_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // start an operation and poll until idle
  task automatic run_op(input logic [2:0] op, input logic otp);
    apb(1'b1, `NSR_OFF_CTRL, {26'h0, 1'b0, otp, op, 1'b1});
    do
      apb(1'b0, `NSR_OFF_CTRL, 32'h0);
    while (rd[0] !== 1'b0);
  endtask
  // status read starts busy, ready arrives under held strobe
  task automatic t_status;
    busy <= 1'b1;
    fork
      run_op(`NSR_OP_STATUS, 1'b0);
      begin
        repeat (80) @(posedge clock_i);
        busy <= 1'b0;
      end
    join
    apb(1'b0, `NSR_OFF_DEVSTAT, 32'h0);
    `CHK("status", 32'h0000_01E0, rd)
    $display("status test done");
  endtask
  // enhanced status while busy, fail only on plane one
  task automatic t_enh;
    busy <= 1'b1;
    fail <= 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, `NSR_OFF_ADDR, (p == 1) ? 32'h0000_0040 : 32'h0);
      run_op(`NSR_OP_ENH, 1'b0);
      apb(1'b0, `NSR_OFF_DEVSTAT, 32'h0);
      `CHK("enh status", (p == 1) ? 32'h0000_0083 : 32'h0000_0080, rd)
    end
    busy <= 1'b0;
    fail <= 1'b0;
    run_op(`NSR_OP_ENH, 1'b1);
    apb(1'b0, `NSR_OFF_STAT, 32'h0);
    `CHK("otp refusal", 1'b1, rd[1])
    run_op(`NSR_OP_NORMAL, 1'b0);
    $display("enhanced status test done");
  endtask
  // id with first copy broken, parameter times, order check, bad address
  task automatic t_pages;
    bad_uid <= 1'b1;
    run_op(`NSR_OP_UID, 1'b0);
    apb(1'b0, `NSR_OFF_STAT, 32'h0);
    `CHK("uid flags", 2'b01, rd[3:2])
    apb(1'b0, `NSR_OFF_UID0, 32'h0);
    `CHK("uid0", 32'hC3C2_C1C0, rd)
    apb(1'b0, `NSR_OFF_UID3, 32'h0);
    `CHK("uid3", 32'hCFCE_CDCC, rd)
    run_op(`NSR_OP_PARAM, 1'b0);
    apb(1'b0, `NSR_OFF_TIMES, 32'h0);
    `CHK("times", 32'h2710_02BC, rd)
    apb(1'b0, `NSR_OFF_GEOM, 32'h0);
    `CHK("geom", 32'h4231_1040, rd)
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, `NSR_OFF_ADDR, (i == 0) ? 32'h0000_0002 : 32'h0000_0001);
      run_op(`NSR_OP_PROGCHK, 1'b0);
      apb(1'b0, `NSR_OFF_STAT, 32'h0);
      `CHK("order flags", {1'b0, i[0]}, rd[5:4])
    end
    apb(1'b0, 12'h030, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    $display("page test done");
  endtask
  // verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    t_status;
    t_enh;
    t_pages;
    tally_and_finish;
  end
  // watchdog
  initial
  begin
    #400000;
    n_fail++;
    tally_and_finish;
  end
endmodule
